// file: wer_pkg.sv
// Purpose: Shared constants and types for the wake-up event router.
// Assumes: One clock, synchronous active-high reset, plain register port.
// Notes:   Event bit positions are shared by all event registers.
// ****************************************************************
// Package
// ****************************************************************
package wer_pkg;
  localparam int NUM_EVENTS = 16;
  localparam int NUM_SOURCES = 16;
  localparam int NUM_TARGETS = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SRC_W = 4;
  localparam int SEL_FIELD_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_EDGE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_SELCFG = 8'h10;
  localparam logic [7:0] OFF_RAWIN = 8'h14;
  localparam logic [7:0] OFF_WAKESTAT = 8'h18;

  // Reset values
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_EDGE = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [31:0] RST_SELCFG = 32'h0000_0000;

  // Event bit positions
  localparam int EV_WAKE0 = 0;
  localparam int EV_RESET_PIN = 4;
  localparam int EV_ALARM = 5;
  localparam int EV_RTC = 6;
  localparam int EV_WATCHDOG = 7;
  localparam int EV_BROWNOUT = 8;
  localparam int EV_CAN = 9;
  localparam int EV_QDEC = 10;
  localparam int EV_ETHERNET = 11;
  localparam int EV_USB_A = 12;
  localparam int EV_USB_B = 13;
  localparam int EV_TIMER_A = 14;
  localparam int EV_TIMER_B = 15;

  // Events able to wake from the deep modes without the 32 kHz oscillator
  localparam logic [15:0] DEEP_WAKE_MASK = 16'h001f;
  // Events that need the 32 kHz oscillator running
  localparam logic [15:0] OSC_WAKE_MASK = 16'h0060;

  // Wake status field positions
  localparam int WS_WAKE_BIT = 0;
  localparam int WS_OSC_BIT = 1;
  localparam int WS_MODE_LSB = 4;

  typedef enum logic [2:0] {
    PM_RUN = 3'b000,
    PM_SLEEP = 3'b001,
    PM_DEEP_SLEEP = 3'b010,
    PM_POWER_DOWN = 3'b011,
    PM_DEEP_PD = 3'b100
  } wer_pmode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wer_bus_req_t;

  // Per-target selector field: bits 3:0 source, bit 4 invert, bit 5 pulse
  typedef struct packed {
    logic [1:0] spare;
    logic pulse;
    logic invert;
    logic [SRC_W-1:0] src;
  } wer_sel_cfg_t;

  typedef struct packed {
    logic captHold;
    logic syncA;
    logic syncB;
    logic prevB;
    logic evOut;
  } wer_gsel_state_t;

  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] edgeCfg;
    logic [15:0] status;
    logic [15:0] mask;
    logic [15:0] prevEv;
    logic [31:0] selCfg;
    logic [31:0] rdata;
    logic wake;
  } wer_state_t;
endpackage : wer_pkg

// file: wer_gsel.sv
// Purpose: One channel of the global input selector.
// Assumes: targetTick marks each active edge of the target clock.
// Notes:   Source pulses shorter than a target period are held.
`timescale 1ns/1ns
// ****************************************************************
// Selector channel
// ****************************************************************
module wer_gsel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [wer_pkg::NUM_SOURCES-1:0] srcIn,
  input wire wer_pkg::wer_sel_cfg_t cfg,
  input wire logic targetTick,
  output logic targetEvent
);
  import wer_pkg::*;

  wer_gsel_state_t st_reg;
  wer_gsel_state_t st_next;
  logic selBit;

  assign selBit = srcIn[cfg.src] ^ cfg.invert;

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.captHold = selBit | (st_reg.captHold & ~targetTick);
    if (targetTick) begin
      st_next.syncA = st_reg.captHold;
      st_next.syncB = st_reg.syncA;
      st_next.prevB = st_reg.syncB;
      st_next.evOut = cfg.pulse ? (st_reg.syncB & ~st_reg.prevB) : st_reg.syncB;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign targetEvent = st_reg.evOut;

  a_pulse_single: assert property (@(posedge clk) disable iff (rst)
    (cfg.pulse && $stable(cfg) && targetEvent && targetTick) |=> !targetEvent)
    else $error("pulse mode output lasted more than one target cycle");
  a_short_capture: assert property (@(posedge clk) disable iff (rst)
    selBit |=> st_reg.captHold)
    else $error("selected source pulse was not captured");
  a_sync_stable: assert property (@(posedge clk) disable iff (rst)
    !targetTick |=> $stable(targetEvent))
    else $error("target event changed outside a target clock edge");
  c_pulse_out: cover property (@(posedge clk) disable iff (rst)
    cfg.pulse && targetEvent);
endmodule : wer_gsel

// file: wer_router.sv
// Purpose: Wake-up and interrupt event router with input selector.
// Assumes: All event inputs synchronous to clk; register port never waits.
// Notes:   Overview of operation
// Overview of operation
// - Enabled, masked-in events raise controller interrupt
// - Wake request to core and clock control
// - Per-event edge or level detection
// - Disabled event gives no interrupt, no wake
// - Wake pins, reset pin wake all modes
// - Alarm, clock events need 32 kHz oscillator
// - Peripheral events wake from sleep only
// - Pending core interrupt wakes from sleep
// - Selector routes one inverted-or-not source
// - Selector captures pulses shorter than target clock
// - Selector synchronizes to target clock
// - Selector optional one-cycle target pulse
`timescale 1ns/1ns
// ****************************************************************
// Event router top
// ****************************************************************
module wer_router (
  input wire logic clk,
  input wire logic rst,
  input wire wer_pkg::wer_bus_req_t busReq,
  output logic [wer_pkg::DATA_W-1:0] busRdata,
  input wire logic [3:0] wakePins,
  input wire logic resetPin,
  input wire logic alarmEvt,
  input wire logic rtcEvt,
  input wire logic watchdogIrq,
  input wire logic brownoutIrq,
  input wire logic canIrq,
  input wire logic qdecIrq,
  input wire logic ethernetEvt,
  input wire logic usbAEvt,
  input wire logic usbBEvt,
  input wire logic osc32kRunning,
  input wire wer_pkg::wer_pmode_t powerMode,
  input wire logic cpuIrqPending,
  input wire logic [wer_pkg::NUM_SOURCES-1:0] selSources,
  input wire logic [wer_pkg::NUM_TARGETS-1:0] targetTick,
  output logic [wer_pkg::NUM_TARGETS-1:0] targetEvents,
  output logic irqToCtrl,
  output logic wakeCore,
  output logic wakeClockCtrl
);
  import wer_pkg::*;

  wer_state_t st_reg;
  wer_state_t st_next;
  logic [NUM_EVENTS-1:0] evIn;
  logic [NUM_EVENTS-1:0] levelHit;
  logic [NUM_EVENTS-1:0] edgeHit;
  logic [NUM_EVENTS-1:0] evHit;
  logic [NUM_EVENTS-1:0] clrMask;
  logic [NUM_EVENTS-1:0] oscOk;
  logic [NUM_EVENTS-1:0] sleepSet;
  logic [NUM_EVENTS-1:0] deepSet;
  logic [NUM_EVENTS-1:0] edgeHeldClr;
  logic wakeNow;

  // ****************************************************************
  // Input selector channels
  // ****************************************************************
  // One selector per target, configured by its byte of selCfg
  generate
    for (genvar t = 0; t < NUM_TARGETS; t++) begin : g_sel
      wer_gsel u_sel (
        .clk(clk),
        .rst(rst),
        .srcIn(selSources),
        .cfg(wer_sel_cfg_t'(st_reg.selCfg[t*SEL_FIELD_W +: SEL_FIELD_W])),
        .targetTick(targetTick[t]),
        .targetEvent(targetEvents[t])
      );
    end
  endgenerate

  // ****************************************************************
  // Event detection
  // ****************************************************************
  // Gather the event vector; timer events come through selector targets 0 and 1
  always_comb begin
    evIn = '0;
    evIn[EV_WAKE0 +: 4] = wakePins;
    evIn[EV_RESET_PIN] = resetPin;
    evIn[EV_ALARM] = alarmEvt;
    evIn[EV_RTC] = rtcEvt;
    evIn[EV_WATCHDOG] = watchdogIrq;
    evIn[EV_BROWNOUT] = brownoutIrq;
    evIn[EV_CAN] = canIrq;
    evIn[EV_QDEC] = qdecIrq;
    evIn[EV_ETHERNET] = ethernetEvt;
    evIn[EV_USB_A] = usbAEvt;
    evIn[EV_USB_B] = usbBEvt;
    evIn[EV_TIMER_A] = targetEvents[0];
    evIn[EV_TIMER_B] = targetEvents[1];
  end

  assign levelHit = st_reg.enable & ~st_reg.edgeCfg & evIn;
  assign edgeHit = st_reg.enable & st_reg.edgeCfg & evIn & ~st_reg.prevEv;
  assign evHit = levelHit | edgeHit;

  // Write-one-to-clear mask for the status register
  assign clrMask = (busReq.wr && busReq.addr == OFF_STATUS) ? busReq.wdata[15:0] : '0;

  // Helper for the edge re-arm check: edge event held while cleared
  assign edgeHeldClr = clrMask & st_reg.enable & st_reg.edgeCfg & evIn & st_reg.prevEv;

  // ****************************************************************
  // Wake-up qualification
  // ****************************************************************
  // oscillator gates alarm and clock
  assign oscOk = osc32kRunning ? '1 : ~OSC_WAKE_MASK;
  assign sleepSet = st_reg.status & oscOk;
  assign deepSet = st_reg.status & oscOk & (DEEP_WAKE_MASK | OSC_WAKE_MASK);

  // Wake decision per power mode
  always_comb begin
    unique case (powerMode)
      PM_RUN: begin
        wakeNow = 1'b0;
      end
      PM_SLEEP: begin
        wakeNow = (|sleepSet) | cpuIrqPending;
      end
      PM_DEEP_SLEEP, PM_POWER_DOWN, PM_DEEP_PD: begin
        wakeNow = |deepSet;
      end
      default: begin
        wakeNow = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Register file and state update
  // ****************************************************************
  // Next state: config writes, sticky status, read data, wake
  always_comb begin
    st_next = st_reg;
    st_next.prevEv = evIn;
    st_next.status = (st_reg.status & ~clrMask) | evHit;
    st_next.wake = wakeNow;
    if (busReq.wr) begin
      unique case (busReq.addr)
        OFF_ENABLE: begin
          st_next.enable = busReq.wdata[15:0];
        end
        OFF_EDGE: begin
          st_next.edgeCfg = busReq.wdata[15:0];
        end
        OFF_MASK: begin
          st_next.mask = busReq.wdata[15:0];
        end
        OFF_SELCFG: begin
          st_next.selCfg = busReq.wdata;
        end
        default: begin
          st_next.selCfg = st_reg.selCfg; // Status and read-only: no store
        end
      endcase
    end
    st_next.rdata = '0;
    if (busReq.rd) begin
      unique case (busReq.addr)
        OFF_ENABLE: begin
          st_next.rdata = {16'h0000, st_reg.enable};
        end
        OFF_EDGE: begin
          st_next.rdata = {16'h0000, st_reg.edgeCfg};
        end
        OFF_STATUS: begin
          st_next.rdata = {16'h0000, st_reg.status};
        end
        OFF_MASK: begin
          st_next.rdata = {16'h0000, st_reg.mask};
        end
        OFF_SELCFG: begin
          st_next.rdata = st_reg.selCfg;
        end
        OFF_RAWIN: begin
          st_next.rdata = {16'h0000, evIn};
        end
        OFF_WAKESTAT: begin
          st_next.rdata[WS_WAKE_BIT] = st_reg.wake;
          st_next.rdata[WS_OSC_BIT] = osc32kRunning;
          st_next.rdata[WS_MODE_LSB +: 3] = powerMode;
        end
        default: begin
          st_next.rdata = '0; // Unmapped reads return zero
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.enable <= RST_ENABLE;
      st_reg.edgeCfg <= RST_EDGE;
      st_reg.mask <= RST_MASK;
      st_reg.selCfg <= RST_SELCFG;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // masked status drives interrupt
  assign irqToCtrl = |(st_reg.status & st_reg.mask);
  assign wakeCore = st_reg.wake;
  assign wakeClockCtrl = st_reg.wake;
  assign busRdata = st_reg.rdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_level_capture: assert property (@(posedge clk) disable iff (rst)
    (levelHit != '0) |=> ((st_reg.status & $past(levelHit)) == $past(levelHit)))
    else $error("enabled level event not latched in status");
  a_edge_rearm: assert property (@(posedge clk) disable iff (rst)
    (edgeHeldClr != '0) |=> ((st_reg.status & $past(edgeHeldClr)) == '0))
    else $error("held edge event set status again after clear");
  a_disabled_silent: assert property (@(posedge clk) disable iff (rst)
    (st_reg.enable == '0) |=> ((st_reg.status & ~$past(st_reg.status)) == '0))
    else $error("status set while all events disabled");
  a_status_hold: assert property (@(posedge clk) disable iff (rst)
    (clrMask == '0) |=> ((st_reg.status & $past(st_reg.status)) == $past(st_reg.status)))
    else $error("status flag lost without a clear");
  a_irq_raise: assert property (@(posedge clk) disable iff (rst)
    ((evHit & st_reg.mask) != '0 && !busReq.wr) |=> irqToCtrl)
    else $error("masked-in event did not raise interrupt");
  a_sleep_cpu_wake: assert property (@(posedge clk) disable iff (rst)
    (powerMode == PM_SLEEP && cpuIrqPending) |=> wakeCore)
    else $error("pending core interrupt did not wake from sleep");
  a_deep_pin_wake: assert property (@(posedge clk) disable iff (rst)
    (powerMode == PM_DEEP_PD && (st_reg.status & DEEP_WAKE_MASK) != '0) |=> wakeCore)
    else $error("wake pin event did not wake from deep power-down");
  a_deep_periph_block: assert property (@(posedge clk) disable iff (rst)
    (powerMode == PM_POWER_DOWN && (st_reg.status & (DEEP_WAKE_MASK | OSC_WAKE_MASK)) == '0)
    |=> !wakeCore)
    else $error("peripheral event woke a deep mode");
  a_osc_gate: assert property (@(posedge clk) disable iff (rst)
    (powerMode == PM_DEEP_SLEEP && !osc32kRunning && (st_reg.status & DEEP_WAKE_MASK) == '0)
    |=> !wakeCore)
    else $error("alarm or clock event woke without oscillator");
  a_status_readback: assert property (@(posedge clk) disable iff (rst)
    (busReq.rd && busReq.addr == OFF_STATUS) |=> (busRdata[15:0] == $past(st_reg.status)))
    else $error("status readback mismatch");
  a_wake_pair: assert property (@(posedge clk) disable iff (rst)
    $rose(wakeCore) |-> wakeClockCtrl && $past(wakeNow))
    else $error("wake request not paired or without cause");
  c_irq_rise: cover property (@(posedge clk) disable iff (rst) $rose(irqToCtrl));
  c_deep_wake: cover property (@(posedge clk) disable iff (rst)
    powerMode == PM_DEEP_PD && wakeCore);
  c_clear_set: cover property (@(posedge clk) disable iff (rst) (clrMask & evHit) != '0);
endmodule : wer_router

// file: wer_far_side.sv
// Purpose: Far-side model: target clock ticks and a watch on both wake lines.
// Assumes: Targets all run at clk divided by TICK_DIV.
// Notes:   wakeSplit is sticky once the two wake lines ever differ.
`timescale 1ns/1ns
// ****************************************************************
// Far side model
// ****************************************************************
module wer_far_side #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wakeCore,
  input wire logic wakeClockCtrl,
  output logic [3:0] targetTick,
  output logic wakeSplit
);
  int tickCnt_reg;

  // Target clock edges as one-cycle strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt_reg <= 0;
      targetTick <= 4'h0;
    end else begin
      tickCnt_reg <= (tickCnt_reg == TICK_DIV - 1) ? 0 : tickCnt_reg + 1;
      targetTick <= {4{tickCnt_reg == TICK_DIV - 1}};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wakeSplit <= 1'b0;
    end else if (wakeCore !== wakeClockCtrl) begin
      wakeSplit <= 1'b1;
    end
  end
endmodule : wer_far_side

// file: wer_router_test.sv
// Purpose: Self-checking bench for the wake-up event router.
// Assumes: Far-side model makes the target ticks.
// Notes:   Random oscillator states and selector source come from a fixed seed.
`timescale 1ns/1ns
// ****************************************************************
// Testbench
// ****************************************************************
module wer_router_test;
  import wer_pkg::*;
  localparam int TICK_DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wer_bus_req_t busReq = '0;
  logic [DATA_W-1:0] busRdata;
  logic [13:0] evIn = '0;
  logic osc32kRunning = 1'b0;
  wer_pmode_t powerMode = PM_RUN;
  logic cpuIrqPending = 1'b0;
  logic [NUM_SOURCES-1:0] selSources = '0;
  logic [NUM_TARGETS-1:0] targetTick;
  logic [NUM_TARGETS-1:0] targetEvents;
  logic irqToCtrl;
  logic wakeCore;
  logic wakeClockCtrl;
  logic wakeSplit;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] offs [5] = '{OFF_ENABLE, OFF_EDGE, OFF_MASK, OFF_SELCFG, 8'h1c};
  logic [3:0] s;
  int n;

  always #4 clk = ~clk;

  wer_router dut (.clk(clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .wakePins(evIn[3:0]), .resetPin(evIn[4]), .alarmEvt(evIn[5]), .rtcEvt(evIn[6]),
    .watchdogIrq(evIn[7]), .brownoutIrq(evIn[8]), .canIrq(evIn[9]), .qdecIrq(evIn[10]),
    .ethernetEvt(evIn[11]), .usbAEvt(evIn[12]), .usbBEvt(evIn[13]),
    .osc32kRunning(osc32kRunning), .powerMode(powerMode), .cpuIrqPending(cpuIrqPending),
    .selSources(selSources), .targetTick(targetTick), .targetEvents(targetEvents),
    .irqToCtrl(irqToCtrl), .wakeCore(wakeCore), .wakeClockCtrl(wakeClockCtrl));

  wer_far_side #(.TICK_DIV(TICK_DIV)) far (.clk(clk), .rst(rst), .wakeCore(wakeCore),
    .wakeClockCtrl(wakeClockCtrl), .targetTick(targetTick), .wakeSplit(wakeSplit));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask : wr

  // Read data is looked at in the one cycle it stands
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 check(busRdata, exp, what);
  endtask : rchk

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : settle

  // Expected wake for one enabled event in a given mode
  function automatic logic wake_exp(input wer_pmode_t m, input int b, input logic osc);
    if (m == PM_RUN || (OSC_WAKE_MASK[b] && !osc)) return 1'b0;
    if (m == PM_SLEEP) return 1'b1;
    return DEEP_WAKE_MASK[b] | OSC_WAKE_MASK[b];
  endfunction : wake_exp

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(82));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values and unmapped read
    foreach (offs[i]) rchk(offs[i], 32'h0, "reset value");
    $display("test reset done");

    // Enabled level event sets sticky status and irq; disabled one does not
    wr(OFF_ENABLE, 32'h1);
    wr(OFF_MASK, 32'h1);
    @(posedge clk);
    evIn[1:0] <= 2'b11;
    settle(3);
    check(irqToCtrl, 1'b1, "irq on enabled event");
    rchk(OFF_STATUS, 32'h1, "only enabled status");
    evIn[1:0] <= 2'b00;
    settle(4);
    rchk(OFF_STATUS, 32'h1, "status held after source drops");
    wr(OFF_STATUS, 32'h1);
    rchk(OFF_STATUS, 32'h0, "status cleared by one");
    check(irqToCtrl, 1'b0, "irq drops with status");
    $display("test level done");

    // Edge event held high sets status once only
    wr(OFF_EDGE, 32'h4);
    wr(OFF_ENABLE, 32'h4);
    @(posedge clk);
    evIn[2] <= 1'b1;
    settle(3);
    rchk(OFF_STATUS, 32'h4, "edge sets status");
    wr(OFF_STATUS, 32'h4);
    rchk(OFF_STATUS, 32'h0, "held level no new edge");
    wr(OFF_EDGE, 32'h0);
    rchk(OFF_STATUS, 32'h4, "level mode re-sets");
    evIn[2] <= 1'b0;
    wr(OFF_STATUS, 32'hffff);
    $display("test edge done");

    // Events 0 to 13 in every mode, oscillator state random
    for (int b = 0; b < 14; b++) begin
      for (int m = 0; m < 5; m++) begin
        wr(OFF_ENABLE, 32'h1 << b);
        powerMode <= wer_pmode_t'(m);
        osc32kRunning <= 1'($urandom_range(1, 0));
        @(posedge clk);
        evIn[b] <= 1'b1;
        settle(3);
        check(wakeCore, wake_exp(wer_pmode_t'(m), b, osc32kRunning), "wake by mode");
        evIn[b] <= 1'b0;
        wr(OFF_STATUS, 32'hffff);
        settle(2);
        check(wakeCore, 1'b0, "wake ends after clear");
      end
    end
    // Disabled event never wakes
    wr(OFF_ENABLE, 32'h0);
    powerMode <= PM_SLEEP;
    evIn <= 14'h3fff;
    settle(4);
    check(wakeCore, 1'b0, "disabled event no wake");
    evIn <= 14'h0;
    $display("test wake done");

    // Pending core interrupt wakes from sleep only
    cpuIrqPending <= 1'b1;
    settle(3);
    check(wakeCore, 1'b1, "core irq wakes sleep");
    powerMode <= PM_DEEP_SLEEP;
    settle(3);
    check(wakeCore, 1'b0, "core irq no deep wake");
    cpuIrqPending <= 1'b0;
    powerMode <= PM_RUN;
    $display("test core irq done");

    // Selector: one-cycle source pulse, pulse mode, routed to event bit 14
    s = 4'($urandom_range(15, 0));
    wr(OFF_SELCFG, {26'h0, 1'b1, 1'b0, s});
    wr(OFF_ENABLE, 32'h1 << EV_TIMER_A);
    @(posedge clk);
    selSources <= 16'h1 << (s ^ 4'h1);
    @(posedge clk);
    selSources <= 16'h0;
    settle(6 * TICK_DIV);
    check(targetEvents, 4'h0, "unselected source ignored");
    @(posedge clk);
    selSources <= 16'h1 << s;
    @(posedge clk);
    selSources <= 16'h0;
    n = 0;
    while (targetEvents[0] !== 1'b1 && n < 10 * TICK_DIV) begin
      settle(1);
      n++;
    end
    check(n < 10 * TICK_DIV, 1'b1, "short pulse delivered");
    if (n >= 10 * TICK_DIV) final_report();
    n = 0;
    while (targetEvents[0] === 1'b1 && n < 10 * TICK_DIV) begin
      settle(1);
      n++;
    end
    check(n, TICK_DIV, "one target cycle pulse");
    rchk(OFF_STATUS, 32'h1 << EV_TIMER_A, "routed event in status");
    // Inverted idle source: steady high, or low once switched to pulse mode
    wr(OFF_SELCFG, {26'h0, 1'b0, 1'b1, s});
    settle(6 * TICK_DIV);
    check(targetEvents[0], 1'b1, "inverted level");
    wr(OFF_SELCFG, {26'h0, 1'b1, 1'b1, s});
    settle(6 * TICK_DIV);
    check(targetEvents[0], 1'b0, "pulse mode ends");
    check(wakeSplit, 1'b0, "wake lines agree");
    $display("test selector done");
    final_report();
  end
endmodule : wer_router_test
